// file: logic/psw_regs.vh
`ifndef PSW_REGS_VH
`define PSW_REGS_VH
// Register byte offsets.
`define PSW_CTRL_OFS      8'h00
`define PSW_MODE_OFS      8'h04
`define PSW_SLP_DLY_OFS   8'h08
`define PSW_WAK_DLY_OFS   8'h0C
`define PSW_SLP_LVL_OFS   8'h10
`define PSW_SLP_SPD_OFS   8'h14
`define PSW_SLP_PWR_OFS   8'h18
`define PSW_WAK_LVL_OFS   8'h1C
`define PSW_WAK_ERR_OFS   8'h20
`define PSW_BST_SPD_OFS   8'h24
`define PSW_BST_TIM_OFS   8'h28
`define PSW_SNS_LO_OFS    8'h2C
`define PSW_SNS_HI_OFS    8'h30
`define PSW_STAT_OFS      8'h34
// Sleep detection modes.
`define PSW_DET_NONE      3'h0
`define PSW_DET_SWITCH    3'h1
`define PSW_DET_FLOW      3'h2
`define PSW_DET_SPEED     3'h3
`define PSW_DET_POWER     3'h4
`define PSW_DET_MULTI     3'h5
// Sensor sources.
`define PSW_SNS_NONE      2'h0
`define PSW_SNS_ANALOG    2'h1
`define PSW_SNS_VIRTUAL   2'h2
`define PSW_SNS_PULSE     2'h3
// Switch sources.
`define PSW_SW_NONE       2'h0
`define PSW_SW_INPUT      2'h1
`define PSW_SW_CMD        2'h2
// Control field positions.
`define PSW_CTRL_FB_BIT   0
`define PSW_CTRL_INV_BIT  1
`define PSW_CTRL_WERR_BIT 2
// Control tick: 10 us at 100 MHz, so delay settings count in 10 us steps.
`define PSW_TICK_NS       10000
`define PSW_CLK_NS        10
`define PSW_TICK_CYC      (`PSW_TICK_NS / `PSW_CLK_NS)
`endif

// file: logic/psw_sleep_wake.v
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "psw_regs.vh"
// Notes on behaviour
// - With no feedback source assigned, the function stays inert.
// - From run, sleep only when no wake condition and sleep condition outlasts delay.
// - Flow mode: sleep condition while sensor value below sleep level.
// - Switch mode: sleep condition when selected switch input is active.
// - Speed mode: sleep condition while output frequency below sleep speed.
// - Power mode: sleep condition while output power below sleep power.
// - Multiple mode ORs switch, flow, speed and power conditions.
// - Wake after wake condition outlasts wake delay, then resume PID.
// - Level wake, direct action: feedback below wake level.
// - Level wake, reverse action: feedback above wake level.
// - Error wake, direct action: feedback below reference minus error.
// - Error wake, reverse action: feedback above reference plus error.
// - On sleep from run, run boost speed for boost time, then stop motor.
// - Boost time zero skips boost and stops directly.
// - Run order in auto with wake condition starts PID at once.
// - Run order in auto without wake condition sleeps, no boost.
// - Switch to auto while running stays running under PID.
// - PID control mode needs PID configured, channel 1 and auto.
// - Switch source selectable: none, digital input or command bit.
// - Sensor source selectable: none, analog, virtual analog or pulse.
// - Sensor scaled with lowest/highest process pair per source.
// - Detection mode resets to not configured, disabling the sleep condition.
module psw_sleep_wake
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        run_order,
   input  wire        channel1_sel,
   input  wire        pid_auto,
   input  wire        motor_running,
   input  wire        sleep_switch_in,
   input  wire        sleep_cmd_bit,
   input  wire [15:0] sensor_analog,
   input  wire [15:0] sensor_virtual,
   input  wire [15:0] sensor_pulse,
   input  wire [15:0] out_freq,
   input  wire [15:0] out_power,
   input  wire [15:0] pid_feedback,
   input  wire [15:0] pid_reference,
   output reg         pid_run_q,
   output reg         boost_q,
   output reg  [15:0] boost_speed_q,
   output reg         motor_stop_q,
   output reg         asleep_q
);

   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_RUN   = 4'b0010;
   localparam [3:0] ST_BOOST = 4'b0100;
   localparam [3:0] ST_SLEEP = 4'b1000;
   localparam [16:0] TICK_MAX = `PSW_TICK_CYC - 1;

   reg [2:0]  ctrl_q;
   reg [2:0]  det_mode_q;
   reg [1:0]  sns_src_q;
   reg [1:0]  sw_src_q;
   reg [15:0] slp_dly_q;
   reg [15:0] wak_dly_q;
   reg [15:0] slp_lvl_q;
   reg [15:0] slp_spd_q;
   reg [15:0] slp_pwr_q;
   reg [15:0] wak_lvl_q;
   reg [15:0] wak_err_q;
   reg [15:0] bst_spd_q;
   reg [15:0] bst_tim_q;
   reg [15:0] sns_lo_q [0:2];
   reg [15:0] sns_hi_q [0:2];
   reg [3:0]  state_q;
   reg [16:0] tick_cnt_q;
   reg        tick_q;
   reg [15:0] slp_cnt_q;
   reg [15:0] wak_cnt_q;
   reg [15:0] bst_cnt_q;
   reg        run_prev_q;
   reg        auto_prev_q;
   reg [7:0]  aw_addr_q;
   reg [31:0] w_data_q;
   reg        aw_have_q;
   reg        w_have_q;

   // Linear scale of a raw 0..FFFF reading into the lo..hi process span.
   function [15:0] scale;
      input [15:0] raw;
      input [15:0] lo;
      input [15:0] hi;
      reg   [31:0] prod;
      begin
         prod  = $signed({hi[15], hi}) - $signed({lo[15], lo});
         prod  = $signed(prod[16:0]) * $signed({1'b0, raw});
         scale = lo + prod[31:16];
      end
   endfunction

   // Signed compare a < b.
   function lt;
      input [15:0] a;
      input [15:0] b;
      begin
         lt = $signed(a) < $signed(b);
      end
   endfunction

   wire fb_assigned = ctrl_q[`PSW_CTRL_FB_BIT];
   wire pid_inv     = ctrl_q[`PSW_CTRL_INV_BIT];
   wire wake_err    = ctrl_q[`PSW_CTRL_WERR_BIT];

   wire pid_mode = fb_assigned & channel1_sel & pid_auto;

   wire sw_act = (sw_src_q == `PSW_SW_INPUT) ? sleep_switch_in :
                 (sw_src_q == `PSW_SW_CMD)   ? sleep_cmd_bit : 1'b0;

   reg [15:0] sns_raw;
   reg [1:0]  sns_idx;
   always @*
   begin
      sns_raw = sensor_analog;
      sns_idx = 2'd0;
      case (sns_src_q)
         `PSW_SNS_VIRTUAL:
         begin
            sns_raw = sensor_virtual;
            sns_idx = 2'd1;
         end
         `PSW_SNS_PULSE:
         begin
            sns_raw = sensor_pulse;
            sns_idx = 2'd2;
         end
         default:
         begin
            sns_raw = sensor_analog;
            sns_idx = 2'd0;
         end
      endcase
   end

   wire [15:0] sns_val = scale(sns_raw, sns_lo_q[sns_idx], sns_hi_q[sns_idx]);

   wire c_flow  = (sns_src_q != `PSW_SNS_NONE) & lt(sns_val, slp_lvl_q);
   wire c_speed = out_freq < slp_spd_q;
   wire c_power = out_power < slp_pwr_q;

   reg sleep_cond;
   always @*
   begin
      case (det_mode_q)
         `PSW_DET_SWITCH: sleep_cond = sw_act;
         `PSW_DET_FLOW:   sleep_cond = c_flow;
         `PSW_DET_SPEED:  sleep_cond = c_speed;
         `PSW_DET_POWER:  sleep_cond = c_power;
         `PSW_DET_MULTI:  sleep_cond = sw_act | c_flow | c_speed | c_power;
         default:         sleep_cond = 1'b0;
      endcase
   end

   // Widened by one bit so reference plus or minus error cannot wrap.
   wire [16:0] ref_lo = {pid_reference[15], pid_reference}
                      - {wak_err_q[15], wak_err_q};
   wire [16:0] ref_hi = {pid_reference[15], pid_reference}
                      + {wak_err_q[15], wak_err_q};
   wire [16:0] fb_x   = {pid_feedback[15], pid_feedback};
   wire [16:0] lvl_x  = {wak_lvl_q[15], wak_lvl_q};
   wire wake_cond = wake_err ?
      (pid_inv ? ($signed(fb_x) > $signed(ref_hi))
               : ($signed(fb_x) < $signed(ref_lo))) :
      (pid_inv ? ($signed(fb_x) > $signed(lvl_x))
               : ($signed(fb_x) < $signed(lvl_x)));

   wire slp_done = slp_cnt_q > slp_dly_q;
   wire wak_done = wak_cnt_q > wak_dly_q;

   // Supervisory sequence; run, boost and sleep advance on the control tick, idle on any clock.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_cnt_q    <= 17'h0_0000;
         tick_q        <= 1'b0;
         state_q       <= ST_IDLE;
         slp_cnt_q     <= 16'h0000;
         wak_cnt_q     <= 16'h0000;
         bst_cnt_q     <= 16'h0000;
         run_prev_q    <= 1'b0;
         auto_prev_q   <= 1'b0;
         pid_run_q     <= 1'b0;
         boost_q       <= 1'b0;
         boost_speed_q <= 16'h0000;
         motor_stop_q  <= 1'b0;
         asleep_q      <= 1'b0;
      end
      else
      begin
         tick_q     <= (tick_cnt_q == TICK_MAX);
         tick_cnt_q <= (tick_cnt_q == TICK_MAX) ? 17'h0_0000
                                                : tick_cnt_q + 17'h0_0001;
         run_prev_q  <= run_order;
         auto_prev_q <= pid_mode;
         if (!pid_mode || !run_order)
         begin
            state_q <= ST_IDLE;
            slp_cnt_q <= 16'h0000;
            wak_cnt_q <= 16'h0000;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  if (run_prev_q && motor_running)
                     state_q <= ST_RUN;
                  else if (wake_cond)
                     state_q <= ST_RUN;
                  else
                     state_q <= ST_SLEEP;
               end
               ST_RUN:
               if (tick_q)
               begin
                  if (sleep_cond && !wake_cond && slp_cnt_q != 16'hFFFF)
                     slp_cnt_q <= slp_cnt_q + 16'h0001;
                  else if (!(sleep_cond && !wake_cond))
                     slp_cnt_q <= 16'h0000;
                  if (sleep_cond && !wake_cond && slp_done)
                  begin
                     slp_cnt_q <= 16'h0000;
                     bst_cnt_q <= 16'h0000;
                     state_q <= (bst_tim_q == 16'h0000) ? ST_SLEEP
                                                        : ST_BOOST;
                  end
               end
               ST_BOOST:
               if (tick_q)
               begin
                  bst_cnt_q <= bst_cnt_q + 16'h0001;
                  if (bst_cnt_q + 16'h0001 >= bst_tim_q)
                     state_q <= ST_SLEEP;
               end
               ST_SLEEP:
               if (tick_q)
               begin
                  if (wake_cond && wak_cnt_q != 16'hFFFF)
                     wak_cnt_q <= wak_cnt_q + 16'h0001;
                  else if (!wake_cond)
                     wak_cnt_q <= 16'h0000;
                  if (wake_cond && wak_done)
                  begin
                     wak_cnt_q <= 16'h0000;
                     state_q   <= ST_RUN;
                  end
               end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
         pid_run_q     <= (state_q == ST_RUN);
         boost_q       <= (state_q == ST_BOOST);
         boost_speed_q <= (state_q == ST_BOOST) ? bst_spd_q : 16'h0000;
         motor_stop_q  <= (state_q == ST_SLEEP);
         asleep_q      <= (state_q == ST_SLEEP) || (state_q == ST_BOOST);
      end
   end

   // AXI4-Lite slave: one write and one read at a time.
   wire [7:0]  wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_have_q ? w_data_q : s_axi_wdata;
   wire aw_ok = aw_have_q | (s_axi_awvalid & s_axi_awready);
   wire w_ok  = w_have_q | (s_axi_wvalid & s_axi_wready);
   wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
   integer i;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         ctrl_q        <= 3'h0;
         det_mode_q    <= `PSW_DET_NONE;
         sns_src_q     <= `PSW_SNS_NONE;
         sw_src_q      <= `PSW_SW_NONE;
         slp_dly_q     <= 16'h0000;
         wak_dly_q     <= 16'h0000;
         slp_lvl_q     <= 16'h0000;
         slp_spd_q     <= 16'h0000;
         slp_pwr_q     <= 16'h0000;
         wak_lvl_q     <= 16'h0000;
         wak_err_q     <= 16'h0000;
         bst_spd_q     <= 16'h0000;
         bst_tim_q     <= 16'h0000;
         for (i = 0; i < 3; i = i + 1)
         begin
            sns_lo_q[i] <= 16'h0000;
            sns_hi_q[i] <= 16'h0000;
         end
      end
      else
      begin
         s_axi_awready <= ~aw_ok & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= ~w_ok & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
         end
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_wr)
         begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= 2'b00;
            // DECERR on unmapped or read-only offsets.
            case (wr_addr)
               `PSW_CTRL_OFS:    ctrl_q    <= wr_data[2:0];
               `PSW_MODE_OFS:
               begin
                  det_mode_q <= wr_data[2:0];
                  sns_src_q  <= wr_data[5:4];
                  sw_src_q   <= wr_data[9:8];
               end
               `PSW_SLP_DLY_OFS: slp_dly_q <= wr_data[15:0];
               `PSW_WAK_DLY_OFS: wak_dly_q <= wr_data[15:0];
               `PSW_SLP_LVL_OFS: slp_lvl_q <= wr_data[15:0];
               `PSW_SLP_SPD_OFS: slp_spd_q <= wr_data[15:0];
               `PSW_SLP_PWR_OFS: slp_pwr_q <= wr_data[15:0];
               `PSW_WAK_LVL_OFS: wak_lvl_q <= wr_data[15:0];
               `PSW_WAK_ERR_OFS: wak_err_q <= wr_data[15:0];
               `PSW_BST_SPD_OFS: bst_spd_q <= wr_data[15:0];
               `PSW_BST_TIM_OFS: bst_tim_q <= wr_data[15:0];
               `PSW_SNS_LO_OFS:
                  if (wr_data[31:30] < 2'd3)
                     sns_lo_q[wr_data[31:30]] <= wr_data[15:0];
               `PSW_SNS_HI_OFS:
                  if (wr_data[31:30] < 2'd3)
                     sns_hi_q[wr_data[31:30]] <= wr_data[15:0];
               default:          s_axi_bresp <= 2'b11;
            endcase
         end
      end
   end

   reg [31:0] rd_data;
   reg        rd_ok;
   always @*
   begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `PSW_CTRL_OFS:    rd_data = {29'h0, ctrl_q};
         `PSW_MODE_OFS:    rd_data = {22'h0, sw_src_q, 2'h0, sns_src_q,
                                      1'b0, det_mode_q};
         `PSW_SLP_DLY_OFS: rd_data = {16'h0000, slp_dly_q};
         `PSW_WAK_DLY_OFS: rd_data = {16'h0000, wak_dly_q};
         `PSW_SLP_LVL_OFS: rd_data = {16'h0000, slp_lvl_q};
         `PSW_SLP_SPD_OFS: rd_data = {16'h0000, slp_spd_q};
         `PSW_SLP_PWR_OFS: rd_data = {16'h0000, slp_pwr_q};
         `PSW_WAK_LVL_OFS: rd_data = {16'h0000, wak_lvl_q};
         `PSW_WAK_ERR_OFS: rd_data = {16'h0000, wak_err_q};
         `PSW_BST_SPD_OFS: rd_data = {16'h0000, bst_spd_q};
         `PSW_BST_TIM_OFS: rd_data = {16'h0000, bst_tim_q};
         `PSW_SNS_LO_OFS:  rd_data = {16'h0000, sns_lo_q[sns_idx]};
         `PSW_SNS_HI_OFS:  rd_data = {16'h0000, sns_hi_q[sns_idx]};
         `PSW_STAT_OFS:    rd_data = {sns_val, 8'h00, wake_cond,
                                      sleep_cond, pid_mode, 1'b0, state_q};
         default:
         begin
            rd_data = 32'h0000_0000;
            rd_ok   = 1'b0;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b11;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// file: dv/psw_sleep_wake_properties.sv
`timescale 1ns/1ps
module psw_sleep_wake_chk
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        run_order,
   input wire logic        channel1_sel,
   input wire logic        pid_auto,
   input wire logic        pid_run_q,
   input wire logic        boost_q,
   input wire logic [15:0] boost_speed_q,
   input wire logic        motor_stop_q,
   input wire logic        asleep_q
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_RUN_LOW:
      assert property (!run_order |-> ##2 !pid_run_q && !asleep_q)
      else $error("outputs active without a run order");
   AST_PID_MODE:
      assert property ((!channel1_sel || !pid_auto) |-> ##2
                       (!pid_run_q && !asleep_q && !motor_stop_q))
      else $error("outputs active outside pid control mode");
   AST_RUN_XOR_SLEEP:
      assert property (!(pid_run_q && asleep_q))
      else $error("regulating and asleep together");
   AST_BOOST_SPD:
      assert property (!boost_q |-> boost_speed_q == 16'h0000)
      else $error("boost speed shown outside boost");
   AST_BOOST_STATE:
      assert property (boost_q |-> asleep_q && !motor_stop_q && !pid_run_q)
      else $error("boost outside the sleep entry");
   AST_STOP_ASLEEP:
      assert property (motor_stop_q |-> asleep_q && !boost_q)
      else $error("motor stop outside sleep");
   AST_BOOST_THEN_STOP:
      assert property ($fell(boost_q) && asleep_q |-> motor_stop_q)
      else $error("boost ended without stopping the motor");
   AST_START_NO_BOOST:
      assert property ($rose(asleep_q) && !$past(pid_run_q) |->
                       !boost_q && motor_stop_q)
      else $error("start into sleep went through boost");
endmodule

bind psw_sleep_wake psw_sleep_wake_chk u_chk
(
   .aclk, .aresetn, .run_order, .channel1_sel, .pid_auto, .pid_run_q,
   .boost_q, .boost_speed_q, .motor_stop_q, .asleep_q
);

// file: dv/psw_plant.sv
`timescale 1ns/1ps
module psw_plant
(
   input  wire logic        aclk,
   input  wire logic        pid_run_q,
   input  wire logic        boost_q,
   input  wire logic [15:0] boost_speed_q,
   input  wire logic        manual_run,
   input  wire logic [15:0] freq_set,
   input  wire logic [15:0] power_set,
   output logic             motor_running,
   output logic [15:0]      out_freq,
   output logic [15:0]      out_power
);
   initial
   begin
      motor_running = 1'b0;
      out_freq = 16'h0000;
      out_power = 16'h0000;
   end
   // The drive answers a cycle late, so nothing may rely on a same-cycle echo.
   always @(posedge aclk)
   begin
      motor_running <= manual_run | pid_run_q | boost_q;
      if (boost_q)
         out_freq <= boost_speed_q;
      else
         out_freq <= (pid_run_q | manual_run) ? freq_set : 16'h0000;
      out_power <= (pid_run_q | manual_run | boost_q) ? power_set : 16'h0000;
   end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, run_order, channel1_sel;
   logic        pid_auto, sleep_switch_in, sleep_cmd_bit, manual_run, out_req;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, seed, m;
   logic [15:0] sensor_analog, sensor_virtual, sensor_pulse;
   logic [15:0] pid_feedback, pid_reference, f_set, p_set;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, motor_running, pid_run_q, boost_q;
   wire         motor_stop_q, asleep_q;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [15:0] out_freq, out_power, boost_speed_q;
   logic [35:0] eq[$];
   logic [35:0] oq[$];
   logic [31:0] mq[$];
   int          error_cnt, checks;

   psw_sleep_wake DUT
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .run_order, .channel1_sel, .pid_auto,
      .motor_running, .sleep_switch_in, .sleep_cmd_bit, .sensor_analog,
      .sensor_virtual, .sensor_pulse, .out_freq, .out_power, .pid_feedback,
      .pid_reference, .pid_run_q, .boost_q, .boost_speed_q, .motor_stop_q,
      .asleep_q
   );
   psw_plant u_plant
   (
      .aclk, .pid_run_q, .boost_q, .boost_speed_q, .manual_run,
      .freq_set(f_set), .power_set(p_set), .motor_running, .out_freq,
      .out_power
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic chk(input logic [35:0] seen, exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      while (!s_axi_bvalid)
         @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] msk, e,
                     input logic [1:0] r = 2'b00);
      eq.push_back({2'b00, r, e});
      mq.push_back(msk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Outputs as {pid_run, boost, stop, asleep, boost speed}.
   task automatic oc(input logic [19:0] e);
      oq.push_back({16'h0000, e});
      out_req <= 1'b1;
      @(posedge aclk);
      out_req <= 1'b0;
      @(posedge aclk);
   endtask

   // Sleep condition in STAT bit 6 while held running by a wake condition.
   task automatic sc(input logic [31:0] md, input logic [15:0] f, p, a,
                     input logic sw, cb, e);
      f_set <= f;
      p_set <= p;
      sensor_analog <= a;
      sleep_switch_in <= sw;
      sleep_cmd_bit <= cb;
      wr(8'h04, md);
      tk(4);
      rd(8'h34, 32'h0000_006F, {25'h0, e, 6'h22});
   endtask

   task automatic wk(input logic [31:0] c, input logic [15:0] fb,
                     input logic e);
      pid_feedback <= fb;
      wr(8'h00, c);
      tk(4);
      rd(8'h34, 32'h0000_0080, {24'h0, e, 7'h00});
   endtask

   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         m = mq.pop_front();
         chk({2'b00, s_axi_rresp, s_axi_rdata & m}, eq.pop_front(), "read");
      end
      if (out_req)
         chk({16'h0000, pid_run_q, boost_q, motor_stop_q, asleep_q,
              boost_speed_q}, oq.pop_front(), "outputs");
   end

   // About eight control ticks of waiting plus set-up, with margin.
   initial
   begin
      repeat (50000) @(posedge aclk);
      error_cnt++;
      stop_test();
   end

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, run_order, channel1_sel} = 4'h0;
      {pid_auto, sleep_switch_in, sleep_cmd_bit, manual_run} = 4'h0;
      {out_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
      {sensor_analog, sensor_virtual, sensor_pulse} = 48'h0;
      {pid_feedback, pid_reference, f_set, p_set} = 64'h0;
      seed = 32'h0000_003D;
      tk(5);
      aresetn <= 1'b1;
      tk(1);
      oc(20'h0_0000);
      rd(8'h04, 32'h0000_0007, 32'h0000_0000);
      rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000, 2'b11);
      wr(8'h1C, 32'h0000_1000);
      pid_feedback <= 16'h0800;
      run_order <= 1'b1;
      channel1_sel <= 1'b1;
      pid_auto <= 1'b1;
      tk(4);
      rd(8'h34, 32'h0000_002F, 32'h0000_0001);
      oc(20'h0_0000);
      wr(8'h00, 32'h0000_0001);
      wr(8'h14, 32'h0000_0064);
      wr(8'h18, 32'h0000_00C8);
      wr(8'h10, 32'h0000_4000);
      wr(8'h20, 32'h0000_0100);
      wr(8'h30, 32'h0000_7FFF);
      channel1_sel <= 1'b0;
      tk(4);
      rd(8'h34, 32'h0000_002F, 32'h0000_0001);
      channel1_sel <= 1'b1;
      run_order <= 1'b0;
      tk(3);
      run_order <= 1'b1;
      tk(4);
      rd(8'h34, 32'h0000_002F, 32'h0000_0022);
      oc(20'h8_0000);
      seed = xs(seed);
      sensor_pulse <= seed[31:16];
      sc(32'h113, 16'h0064 + seed[11:0], 16'h0100, 16'h9000, 0, 0, 0);
      sc(32'h113, 16'h0063, 16'h0100, 16'h9000, 0, 0, 1);
      sc(32'h114, 16'h0200, 16'h00C8, 16'h9000, 0, 0, 0);
      sc(32'h114, 16'h0200, 16'h00C7, 16'h9000, 0, 0, 1);
      sc(32'h112, 16'h0200, 16'h0100, 16'h8000, 0, 0, 1);
      rd(8'h34, 32'hFFFF_0000, 32'h3FFF_0000);
      sc(32'h112, 16'h0200, 16'h0100, 16'h9000, 0, 0, 0);
      sc(32'h102, 16'h0200, 16'h0100, 16'h8000, 0, 0, 0);
      sc(32'h132, 16'h0200, 16'h0100, 16'h9000, 0, 0, 1);
      sc(32'h111, 16'h0200, 16'h0100, 16'h9000, 1, 0, 1);
      sc(32'h111, 16'h0200, 16'h0100, 16'h9000, 0, 1, 0);
      sc(32'h211, 16'h0200, 16'h0100, 16'h9000, 0, 1, 1);
      sc(32'h011, 16'h0200, 16'h0100, 16'h9000, 1, 0, 0);
      sc(32'h115, 16'h0200, 16'h0100, 16'h9000, 0, 0, 0);
      sc(32'h115, 16'h0200, 16'h00C7, 16'h9000, 0, 0, 1);
      sc(32'h110, 16'h0063, 16'h0100, 16'h9000, 0, 0, 0);
      pid_reference <= 16'h2000;
      wk(32'h0000_0001, 16'h0FFF, 1);
      wk(32'h0000_0001, 16'h1000, 0);
      wk(32'h0000_0003, 16'h1001, 1);
      wk(32'h0000_0003, 16'h1000, 0);
      wk(32'h0000_0005, 16'h1EFF, 1);
      wk(32'h0000_0005, 16'h1F00, 0);
      wk(32'h0000_0007, 16'h2101, 1);
      wk(32'h0000_0007, 16'h2100, 0);
      wk(32'h0000_0001, 16'h2000, 0);
      run_order <= 1'b0;
      tk(3);
      run_order <= 1'b1;
      tk(4);
      oc(20'h3_0000);
      rd(8'h34, 32'h0000_000F, 32'h0000_0008);
      pid_auto <= 1'b0;
      manual_run <= 1'b1;
      tk(4);
      pid_auto <= 1'b1;
      tk(4);
      oc(20'h8_0000);
      manual_run <= 1'b0;
      wr(8'h24, 32'h0000_0300);
      wr(8'h28, 32'h0000_0001);
      f_set <= 16'h0032;
      wr(8'h04, 32'h0000_0113);
      while (!boost_q)
         @(posedge aclk);
      tk(1);
      oc(20'h5_0300);
      while (!motor_stop_q)
         @(posedge aclk);
      tk(1);
      oc(20'h3_0000);
      pid_feedback <= 16'h0800;
      while (!pid_run_q)
         @(posedge aclk);
      tk(1);
      oc(20'h8_0000);
      wr(8'h28, 32'h0000_0000);
      pid_feedback <= 16'h2000;
      while (!asleep_q)
         @(posedge aclk);
      tk(1);
      oc(20'h3_0000);
      stop_test();
   end
endmodule
